// ===== inc/spm_pkg.sv
// spm_pkg: register map, field positions, reset values and divider counts
// of the serial port mode and clock select block.
// assumes a 32-bit APB slave with one aligned word per register.
package spm_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] SPM_CTRL_OFS = 8'h00;
   localparam logic [7:0] SPM_DIR_OFS  = 8'h04;
   localparam logic [7:0] SPM_DATA_OFS = 8'h08;
   localparam logic [7:0] SPM_STAT_OFS = 8'h0C;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int SPM_CTRL_EN_POS   = 0;  // serial_pin_enable
   localparam int SPM_CTRL_MLO_POS  = 1;  // mode_sel_lo
   localparam int SPM_CTRL_MHI_POS  = 2;  // mode_sel_hi
   localparam int SPM_CTRL_CLO_POS  = 3;  // clk_src_sel_lo
   localparam int SPM_CTRL_CHI_POS  = 4;  // clk_src_sel_hi
   localparam int SPM_CTRL_PEN_POS  = 5;  // parity_enable
   localparam int SPM_CTRL_PODD_POS = 6;  // odd parity when set
   localparam int SPM_CTRL_OSC_POS  = 7;  // high_speed_oscillator on
   localparam int SPM_CTRL_RDY_POS  = 8;  // slave ready request

   // ------------------------------------------------------------
   // mode and clock source codes (high bit first)
   // ------------------------------------------------------------
   localparam logic [1:0] SPM_MODE_MASTER = 2'h0;
   localparam logic [1:0] SPM_MODE_SLAVE  = 2'h1;
   localparam logic [1:0] SPM_MODE_ASYNC7 = 2'h2;
   localparam logic [1:0] SPM_MODE_ASYNC8 = 2'h3;
   localparam logic [1:0] SPM_SRC_DIV16   = 2'h0;
   localparam logic [1:0] SPM_SRC_DIV8    = 2'h1;
   localparam logic [1:0] SPM_SRC_DIV4    = 2'h2;
   localparam logic [1:0] SPM_SRC_TIMER   = 2'h3;

   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [1:0] SPM_MODE_RST    = SPM_MODE_MASTER;
   localparam logic [1:0] SPM_SRC_RST     = SPM_SRC_DIV16;
   localparam logic [3:0] SPM_DIR_RST     = 4'h0;
   localparam logic [3:0] SPM_DATA_RST    = 4'hF;
   localparam logic [3:0] SPM_BIT_DIV_MAX = 4'hF;   // further divide by 16
   localparam logic [3:0] SPM_SYNC_BITS   = 4'h8;
   localparam logic [3:0] SPM_ASYNC7_BITS = 4'h7;
   localparam logic [3:0] SPM_ASYNC8_BITS = 4'h8;

   typedef struct packed {
      logic        en;
      logic [1:0]  mode;
      logic [1:0]  csrc;
      logic        par_en;
      logic        par_odd;
      logic        osc_on;
      logic        slv_rdy;
      logic [3:0]  dir;
      logic [3:0]  dat;
      logic [3:0]  pin_s1;
      logic [3:0]  pin_s2;
      logic        sclk_s3;
      logic [3:0]  pre_cnt;
      logic        tmr_half;
      logic [3:0]  bit_cnt;
      logic        bit_tick;
      logic [31:0] prdata;
      logic        err;
   } spm_state_t;

endpackage

// ===== rtl/spm_serial_cfg.sv
// spm_serial_cfg: mode select, shared pin routing and bit clock generation
// for a serial port; registers reached over APB.
// assumes OSC_TICK and TMR_UFL are one-cycle pulses on CLK, SER_TXD and
// SER_IDLE come from shift logic on CLK, and pins are asynchronous.
//
// Operation
// - full duplex only in asynchronous modes
// - synchronous modes carry eight data bits
// - async 7 or 8 bits, optional parity
// - pins 0..3 carry din, dout, clock, ready
// - pins stay general purpose after reset
// - serial function overrides general direction bit
// - ready only in slave; async frees clock
// - mode 11,10,01,00 = a8,a7,slave,master
// - mode resets to synchronous master
// - master drives internal clock on clock pin
// - slave uses pin clock, ignores source
// - slave drives ready_n from operating status
// - source 11,10,01,00 = timer,/4,/8,/16
// - timer underflow pulses halved for source
// - clock source resets to oscillator/16
// - selected source divided by sixteen more
// - slave bit clock is pin clock undivided
// - oscillator held off after reset
// - synchronous eight bits LSB first, half duplex
`timescale 1ns/100ps

module spm_serial_cfg
   import spm_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // clock sources
   input  wire logic        OSC_TICK,
   input  wire logic        TMR_UFL,
   // shift logic side
   input  wire logic        SER_TXD,
   input  wire logic        SER_IDLE,
   output logic             SER_RXD,
   output logic             BIT_TICK,
   output logic             FULL_DUPLEX,
   output logic             SYNC_MODE,
   output logic [3:0]       CHAR_BITS,
   output logic             PARITY_EN,
   output logic             PARITY_ODD,
   // shared pins
   input  wire logic [3:0]  PIN_I,
   output logic [3:0]       PIN_O,
   output logic [3:0]       PIN_OE
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // true when the serial function owns shared pin idx
   function automatic logic serial_owns(input int idx, input logic en, input logic [1:0] mode);
      logic own;
      own = 1'b0;
      if (en) begin
         unique case (idx)
            0, 1:    own = 1'b1;
            2:       own = (mode[1] == 1'b0);
            default: own = (mode == SPM_MODE_SLAVE);
         endcase
      end
      return own;
   endfunction

   // prescaler wrap for the oscillator divided sources
   function automatic logic div_hit(input logic [1:0] src, input logic [3:0] cnt);
      logic hit;
      hit = 1'b0;
      unique case (src)
         SPM_SRC_DIV4:  hit = (cnt[1:0] == 2'h3);
         SPM_SRC_DIV8:  hit = (cnt[2:0] == 3'h7);
         SPM_SRC_DIV16: hit = (cnt == 4'hF);
         default:       hit = 1'b0;
      endcase
      return hit;
   endfunction

   spm_state_t s_r;
   spm_state_t s_nxt;
   logic       slave;
   logic       src_tick;
   logic       slv_edge;
   logic       apb_wr;
   logic       apb_setup;
   logic [31:0] rd_val;
   logic [3:0] data_rd;

   assign slave     = s_r.en && (s_r.mode == SPM_MODE_SLAVE);
   assign apb_wr    = PSEL && PENABLE && PWRITE;
   assign apb_setup = PSEL && !PENABLE;

   // ------------------------------------------------------------
   // bit clock sources
   // ------------------------------------------------------------
   always_comb begin
      if (s_r.csrc == SPM_SRC_TIMER) begin
         src_tick = TMR_UFL && s_r.tmr_half;
      end else begin
         src_tick = s_r.osc_on && OSC_TICK && div_hit(s_r.csrc, s_r.pre_cnt);
      end
   end

   // falling edge of the synchronised clock pin, read from the second stage
   assign slv_edge = s_r.sclk_s3 && !s_r.pin_s2[2];

   // ------------------------------------------------------------
   // register read mux
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (serial_owns(i, s_r.en, s_r.mode) || s_r.dir[i]) begin
            data_rd[i] = s_r.dat[i];
         end else begin
            data_rd[i] = s_r.pin_s2[i];
         end
      end
      rd_val = 32'h0000_0000;
      unique case (PADDR)
         SPM_CTRL_OFS: rd_val = {23'h00_0000, s_r.slv_rdy, s_r.osc_on, s_r.par_odd, s_r.par_en,
                                 s_r.csrc, s_r.mode, s_r.en};
         SPM_DIR_OFS:  rd_val = {28'h000_0000, s_r.dir};
         SPM_DATA_OFS: rd_val = {28'h000_0000, data_rd};
         SPM_STAT_OFS: rd_val = {20'h0_0000, s_r.bit_cnt, s_r.pin_s2, SER_IDLE, slave,
                                 FULL_DUPLEX, SYNC_MODE};
         default:      rd_val = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      // two-stage synchroniser on all pins
      s_nxt.pin_s1  = PIN_I;
      s_nxt.pin_s2  = s_r.pin_s1;
      s_nxt.sclk_s3 = s_r.pin_s2[2];
      // oscillator prescaler
      if (s_r.osc_on && OSC_TICK) begin
         s_nxt.pre_cnt = s_r.pre_cnt + 4'h1;
      end
      if (TMR_UFL) begin
         s_nxt.tmr_half = !s_r.tmr_half;
      end
      // bit clock: divide by sixteen, or pin clock in slave mode
      s_nxt.bit_tick = 1'b0;
      if (slave) begin
         s_nxt.bit_tick = slv_edge;
      end else if (src_tick) begin
         s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
         s_nxt.bit_tick = (s_r.bit_cnt == SPM_BIT_DIV_MAX);
      end
      // apb setup cycle captures answer
      if (apb_setup) begin
         s_nxt.prdata = rd_val;
         s_nxt.err    = !(PADDR == SPM_CTRL_OFS || PADDR == SPM_DIR_OFS ||
                          PADDR == SPM_DATA_OFS || PADDR == SPM_STAT_OFS);
      end
      // apb write at access edge
      if (apb_wr && !s_r.err) begin
         unique case (PADDR)
            SPM_CTRL_OFS: begin
               s_nxt.en      = PWDATA[SPM_CTRL_EN_POS];
               s_nxt.mode    = {PWDATA[SPM_CTRL_MHI_POS], PWDATA[SPM_CTRL_MLO_POS]};
               s_nxt.csrc    = {PWDATA[SPM_CTRL_CHI_POS], PWDATA[SPM_CTRL_CLO_POS]};
               s_nxt.par_en  = PWDATA[SPM_CTRL_PEN_POS];
               s_nxt.par_odd = PWDATA[SPM_CTRL_PODD_POS];
               s_nxt.osc_on  = PWDATA[SPM_CTRL_OSC_POS];
               s_nxt.slv_rdy = PWDATA[SPM_CTRL_RDY_POS];
            end
            SPM_DIR_OFS:  s_nxt.dir = PWDATA[3:0];
            SPM_DATA_OFS: s_nxt.dat = PWDATA[3:0];
            default:      s_nxt.dat = s_r.dat;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         s_r         <= '0;
         s_r.mode    <= SPM_MODE_RST;
         s_r.csrc    <= SPM_SRC_RST;
         s_r.osc_on  <= 1'b0;
         s_r.en      <= 1'b0;
         s_r.dir     <= SPM_DIR_RST;
         s_r.dat     <= SPM_DATA_RST;
         s_r.pin_s1  <= 4'hF;
         s_r.pin_s2  <= 4'hF;
         s_r.sclk_s3 <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign PREADY   = 1'b1;
   assign PRDATA   = s_r.prdata;
   assign PSLVERR  = PSEL && PENABLE && s_r.err;
   assign BIT_TICK = s_r.bit_tick;
   assign SER_RXD  = s_r.pin_s2[0];
   assign SYNC_MODE   = (s_r.mode[1] == 1'b0);
   assign FULL_DUPLEX = s_r.mode[1];
   assign PARITY_EN   = s_r.mode[1] && s_r.par_en;
   assign PARITY_ODD  = s_r.par_odd;

   always_comb begin
      unique case (s_r.mode)
         SPM_MODE_ASYNC7: CHAR_BITS = SPM_ASYNC7_BITS;
         SPM_MODE_ASYNC8: CHAR_BITS = SPM_ASYNC8_BITS;
         default:         CHAR_BITS = SPM_SYNC_BITS;
      endcase
   end

   // pin routing: serial function overrides the direction bit
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         PIN_O[i]  = s_r.dat[i];
         PIN_OE[i] = s_r.dir[i];
      end
      if (serial_owns(0, s_r.en, s_r.mode)) begin
         PIN_OE[0] = 1'b0;
      end
      if (serial_owns(1, s_r.en, s_r.mode)) begin
         PIN_O[1]  = SER_TXD;
         PIN_OE[1] = 1'b1;
      end
      if (serial_owns(2, s_r.en, s_r.mode)) begin
         PIN_O[2]  = !s_r.bit_cnt[3];
         PIN_OE[2] = !slave;
      end
      if (serial_owns(3, s_r.en, s_r.mode)) begin
         PIN_O[3]  = !(s_r.slv_rdy && SER_IDLE);
         PIN_OE[3] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   reset_values_a: assert property (@(posedge CLK) $rose(RSTN) |->
      s_r.mode == SPM_MODE_MASTER && s_r.csrc == SPM_SRC_DIV16 && !s_r.osc_on && !s_r.en)
      else $error("reset values of mode, source or oscillator wrong");

   gpio_pins_a: assert property (!s_r.en |-> PIN_OE == s_r.dir && PIN_O == s_r.dat)
      else $error("pins not general purpose while serial disabled");

   data_pins_a: assert property (s_r.en |-> PIN_OE[1] && !PIN_OE[0] && PIN_O[1] == SER_TXD)
      else $error("data pins not routed to serial function");

   async_free_a: assert property (s_r.en && s_r.mode[1] |-> PIN_OE[3:2] == s_r.dir[3:2])
      else $error("clock or ready pin held in asynchronous mode");

   master_clk_a: assert property (s_r.en && s_r.mode == SPM_MODE_MASTER |->
      PIN_OE[2] && PIN_O[2] == !s_r.bit_cnt[3] && PIN_OE[3] == s_r.dir[3])
      else $error("master clock not driven on clock pin");

   slave_tick_a: assert property (slave && s_r.sclk_s3 && !s_r.pin_s2[2] && $stable(slave) |=>
      BIT_TICK)
      else $error("slave pin clock edge gave no bit tick");

   div_sixteen_a: assert property (!slave && src_tick && s_r.bit_cnt == 4'hF |=>
      BIT_TICK && s_r.bit_cnt == 4'h0 ##1 !BIT_TICK)
      else $error("bit tick not at sixteenth source tick");

   timer_half_a: assert property (s_r.csrc == SPM_SRC_TIMER && TMR_UFL |->
      src_tick == s_r.tmr_half ##1 s_r.tmr_half != $past(s_r.tmr_half))
      else $error("timer underflow not halved");

   div_four_a: assert property (s_r.csrc == SPM_SRC_DIV4 && s_r.osc_on && OSC_TICK |->
      src_tick == (s_r.pre_cnt[1:0] == 2'h3))
      else $error("oscillator divide by four wrong");

   osc_off_a: assert property (!s_r.osc_on && s_r.csrc != SPM_SRC_TIMER |-> !src_tick)
      else $error("oscillator source ticks while oscillator off");

   ready_out_a: assert property (slave && SER_IDLE && s_r.slv_rdy |-> !PIN_O[3] && PIN_OE[3])
      else $error("slave ready not driven low when ready");

   width_mode_a: assert property (CHAR_BITS == ((s_r.mode == SPM_MODE_ASYNC7) ? 4'h7 : 4'h8)
      && FULL_DUPLEX == (s_r.mode == SPM_MODE_ASYNC7 || s_r.mode == SPM_MODE_ASYNC8))
      else $error("character width or duplex wrong for mode");

endmodule

// ===== bench/spm_peer.sv
// spm_peer: external serial master on the shared pins.
// assumes the bench resolves pin levels with pull-ups.
`timescale 1ns/100ps
module spm_peer (
   // clock
   input  wire logic       CLK,
   // control
   input  wire logic       go,
   input  wire logic [7:0] tx,
   input  wire logic [3:0] half,
   // pins
   output logic            sclk_o,
   output logic            sdat_o,
   output logic            oe
);
   initial begin
      {sclk_o, sdat_o, oe} = 3'b110;
      forever begin
         @(posedge CLK);
         if (go) begin
            oe <= 1'b1;
            for (int b = 0; b < 8; b++) begin
               sclk_o <= 1'b0;
               sdat_o <= tx[b];
               repeat (half) @(posedge CLK);
               sclk_o <= 1'b1;
               repeat (half) @(posedge CLK);
            end
            // clock stands still, lines float up
            oe <= 1'b0;
         end
      end
   end
endmodule

// ===== bench/spm_serial_cfg_bench.sv
// spm_serial_cfg_bench: self-checking bench for spm_serial_cfg.
// assumes pull-ups on all shared pins and a serial master peer.
`timescale 1ns/100ps
module spm_serial_cfg_bench;
   import spm_pkg::*;
   logic        CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [7:0]  PADDR, ptx;
   logic [31:0] PWDATA, PRDATA, rd, r;
   logic        OSC_TICK, TMR_UFL, SER_TXD, SER_IDLE, SER_RXD, BIT_TICK;
   logic        FULL_DUPLEX, SYNC_MODE, PARITY_EN, PARITY_ODD, er;
   logic [3:0]  CHAR_BITS, PIN_O, PIN_OE, dir, dat, phalf, msk;
   wire  [3:0]  PIN_I;
   logic [1:0]  md;
   logic        pgo, pclk, pdat, poe;
   int          fails, check_count, seed, c;
   spm_serial_cfg i_spm_serial_cfg (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE,
      .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OSC_TICK, .TMR_UFL,
      .SER_TXD, .SER_IDLE, .SER_RXD, .BIT_TICK, .FULL_DUPLEX, .SYNC_MODE,
      .CHAR_BITS, .PARITY_EN, .PARITY_ODD, .PIN_I, .PIN_O, .PIN_OE);
   spm_peer i_spm_peer (.CLK, .go(pgo), .tx(ptx), .half(phalf),
      .sclk_o(pclk), .sdat_o(pdat), .oe(poe));
   assign PIN_I[0] = PIN_OE[0] ? PIN_O[0] : (poe ? pdat : 1'b1);
   assign PIN_I[1] = PIN_OE[1] ? PIN_O[1] : 1'b1;
   assign PIN_I[2] = PIN_OE[2] ? PIN_O[2] : (poe ? pclk : 1'b1);
   assign PIN_I[3] = PIN_OE[3] ? PIN_O[3] : 1'b1;
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL    <= 1'b1;
      PWRITE  <= wr;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic next_tick(output int t);
      t = 0;
      do begin
         @(posedge CLK);
         t++;
      end while (BIT_TICK !== 1'b1 && t < 2000);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // pin direction per mode, general bit where the pin is freed
   function automatic logic [3:0] exp_oe(logic [1:0] m, logic [3:0] d);
      exp_oe = {m == SPM_MODE_SLAVE ? 1'b1 : d[3],
                m == SPM_MODE_MASTER ? 1'b1 : (m == SPM_MODE_SLAVE ? 1'b0 : d[2]), 2'b10};
   endfunction
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      CLK = 0;
      forever #12.5 CLK = ~CLK;
   end
   initial begin
      #(25 * 30000);
      fails++;
      complete_run;
   end
   initial begin
      {RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, SER_TXD, SER_IDLE, pgo} = 0;
      {OSC_TICK, TMR_UFL, ptx, phalf} = {2'b11, 12'h0_02};
      seed = 32'ha7d5_8a5f;
      repeat (16) @(posedge CLK);
      RSTN <= 1'b1;
      @(posedge CLK);
      #1;
      check("oe rst", PIN_OE, 4'h0);
      check("out rst", PIN_O, 4'hF);
      check("sync rst", SYNC_MODE, 1'b1);
      check("pready", PREADY, 1'b1);
      apb(0, SPM_CTRL_OFS, 0);
      check("ctrl rst", rd, 32'h0000_0000);
      next_tick(c);
      check("osc off", c, 2000);
      apb(0, 8'h10, 0);
      check("unmapped", {rd[30:0], er}, 32'h0000_0001);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         md  = m[1:0];
         r   = $random(seed);
         dir = r[7:4];
         dat = r[11:8];
         apb(1, SPM_DIR_OFS, {28'h0, dir});
         apb(1, SPM_DATA_OFS, {28'h0, dat});
         SER_TXD  <= r[3];
         SER_IDLE <= r[4];
         apb(1, SPM_CTRL_OFS, {23'h0, r[2], 1'b0, r[1:0], 2'b00, md, 1'b1});
         @(posedge CLK);
         #1;
         msk = {1'b1, md[1], 2'b10};
         check("duplex", FULL_DUPLEX, md[1]);
         check("sync", SYNC_MODE, !md[1]);
         check("bits", CHAR_BITS, md == SPM_MODE_ASYNC7 ? 4'h7 : 4'h8);
         check("parity", PARITY_EN, r[0] & md[1]);
         check("oe", PIN_OE, exp_oe(md, dir));
         check("out", PIN_O & msk, {md == SPM_MODE_SLAVE ? !(r[2] & r[4]) : dat[3],
               dat[2], r[3], 1'b0} & msk);
         check("odd", PARITY_ODD, r[1]);
         apb(0, SPM_DIR_OFS, 0);
         check("dir", rd, {28'h0, dir});
      end
      $display("test modes done");
      for (int s = 0; s < 4; s++) begin
         apb(1, SPM_CTRL_OFS, 32'h0000_0081 | (s << 3));
         next_tick(c);
         next_tick(c);
         check("divider", c, 32'd256 >> s);
      end
      $display("test divider done");
      apb(1, SPM_CTRL_OFS, 32'h0000_011B);
      r     = $random(seed);
      ptx   = r[7:0];
      phalf = 4'd2 + r[9:8];
      pgo   <= 1'b1;
      SER_IDLE <= 1'b1;
      @(posedge CLK);
      pgo   <= 1'b0;
      for (int b = 0; b < 8; b++) begin
         c = 0;
         while (PIN_I[2] !== 1'b0 && c < 50) begin
            @(posedge CLK);
            c++;
         end
         next_tick(c);
         check("slave tick", c, 3);
         check("rxd", SER_RXD, ptx[b]);
         while (PIN_I[2] !== 1'b1) @(posedge CLK);
      end
      check("ready low", PIN_O[3], 1'b0);
      SER_IDLE <= 1'b0;
      next_tick(c);
      check("slave idle", c, 2000);
      check("ready high", PIN_O[3], 1'b1);
      $display("test slave done");
      RSTN <= 1'b0;
      repeat (3) @(posedge CLK);
      RSTN <= 1'b1;
      apb(0, SPM_CTRL_OFS, 0);
      check("ctrl rerst", rd, 32'h0000_0000);
      check("oe rerst", PIN_OE, 4'h0);
      $display("test reset again done");
      complete_run;
   end
endmodule
